// [hw/fault_code_consts.vh]
// Constants for the compound fault code encoder and its register bank
`ifndef FAULT_CODE_CONSTS_VH
`define FAULT_CODE_CONSTS_VH
// Register byte offsets
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_MASK        12'h008
`define OFS_LOG         12'h00C
`define OFS_EVENTS      12'h010
// Control bits
`define CTRL_EN_BIT     0
`define CTRL_OVWR_BIT   1
`define CTRL_RST        2'h1
// Log register fields
`define LOG_VALID_BIT   31
`define LOG_OVER_BIT    30
`define LOG_CLASS_LSB   16
// Event status bits
`define EV_TLB_BIT      0
`define EV_CACHE_BIT    1
`define EV_BUS_BIT      2
`define EV_OVER_BIT     3
`define EV_W            4
`define MASK_RST        4'h0
// Code prefixes
`define PFX_TLB         12'h001
`define PFX_CACHE       8'h01
`define PFX_BUS         5'h01
// Transaction type
`define TT_INSTR        2'h0
`define TT_DATA         2'h1
`define TT_GEN          2'h2
// Hierarchy level
`define LL_L0           2'h0
`define LL_L1           2'h1
`define LL_L2           2'h2
`define LL_GEN          2'h3
// Request kind
`define RQ_GEN_ERR      4'h0
`define RQ_GEN_RD       4'h1
`define RQ_GEN_WR       4'h2
`define RQ_DATA_RD      4'h3
`define RQ_DATA_WR      4'h4
`define RQ_IFETCH       4'h5
`define RQ_PREFETCH     4'h6
`define RQ_EVICT        4'h7
`define RQ_SNOOP        4'h8
// Participation
`define PP_ORIG         2'h0
`define PP_ANSW         2'h1
`define PP_THIRD        2'h2
`define PP_GEN          2'h3
// Space kind
`define SK_MEM          2'h0
`define SK_IO           2'h2
`define SK_OTHER        2'h3
`endif

// [hw/fault_code_encoder.v]
// Compound fault code encoder with logging register and APB slave
//
// Local design decisions: the address map and the APB slave port.
module fault_code_encoder
(
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Fault detector reports, one-cycle strobes
   input  wire        tlb_fault,
   input  wire        cache_fault,
   input  wire        bus_fault,
   // Transaction origin: instruction, data, or neither known
   input  wire        instr_known,
   input  wire        data_known,
   // Hierarchy level, with a flag for an undetermined level
   input  wire [1:0]  level_in,
   input  wire        level_known,
   // Action: read, write, prefetch, eviction, snoop, or none known
   input  wire        is_read,
   input  wire        is_write,
   input  wire        is_prefetch,
   input  wire        is_evict,
   input  wire        is_snoop,
   // Bus fault details
   input  wire        originator_role,
   input  wire        answering_role,
   input  wire        third_party_role,
   input  wire        timed_out,
   input  wire        mem_access,
   input  wire        io_access,
   // Encoded code, valid flag and interrupt
   output reg  [15:0] arch_fault_code,
   output reg         code_valid,
   output reg         irq
);
`include "fault_code_consts.vh"

   reg  [1:0]  transaction_type_field;
   reg  [1:0]  hierarchy_level_field;
   reg  [3:0]  request_kind_field;
   reg  [3:0]  req_noncache;
   reg  [1:0]  participation_field;
   reg  [1:0]  space_kind_field;
   reg  [15:0] code_nxt;
   reg  [1:0]  class_nxt;
   reg  [1:0]  ctrl_r;
   reg  [3:0]  mask_r;
   reg  [3:0]  status_r;
   reg  [3:0]  status_nxt;
   reg  [15:0] code_r;
   reg  [1:0]  class_r;
   reg         valid_r;
   reg         over_r;
   reg  [31:0] events_r;
   reg  [31:0] rdata_nxt;
   wire        any_fault;
   wire        wr_en;
   wire        rd_en;
   wire        enabled;
   wire        can_log;
   wire [3:0]  ev_set;

   assign any_fault = tlb_fault | cache_fault | bus_fault;
   assign wr_en     = psel & penable & pwrite;
   assign rd_en     = psel & penable & ~pwrite;
   assign enabled   = ctrl_r[`CTRL_EN_BIT];

   // Sub-field encoding; unknowns fall back to the generic codes
   always @*
   begin
      if (instr_known && !data_known)
         transaction_type_field = `TT_INSTR;
      else if (data_known && !instr_known)
         transaction_type_field = `TT_DATA;
      else
         transaction_type_field = `TT_GEN;
      // Level 3 from a detector already means generic
      if (!level_known)
         hierarchy_level_field = `LL_GEN;
      else
         hierarchy_level_field = level_in;
      // Request kind; read and write both set counts as undetermined
      if (is_read && !is_write)
      begin
         if (instr_known && !data_known)
            req_noncache = `RQ_IFETCH;
         else if (data_known && !instr_known)
            req_noncache = `RQ_DATA_RD;
         else
            req_noncache = `RQ_GEN_RD;
      end
      else if (is_write && !is_read)
      begin
         if (data_known && !instr_known)
            req_noncache = `RQ_DATA_WR;
         else
            req_noncache = `RQ_GEN_WR;
      end
      else if (is_prefetch)
         req_noncache = `RQ_PREFETCH;
      else
         req_noncache = `RQ_GEN_ERR;
      // Eviction and snoop only when the cache layout wins; a coincident
      // bus fault takes the bus layout, which must not carry them
      if (cache_fault && !bus_fault && is_evict)
         request_kind_field = `RQ_EVICT;
      else if (cache_fault && !bus_fault && is_snoop)
         request_kind_field = `RQ_SNOOP;
      else
         request_kind_field = req_noncache;
      // Participation; more than one role claimed means generic
      case ({third_party_role, answering_role, originator_role})
         3'h1:    participation_field = `PP_ORIG;
         3'h2:    participation_field = `PP_ANSW;
         3'h4:    participation_field = `PP_THIRD;
         default: participation_field = `PP_GEN;
      endcase
      // Reserved space code 01 can never be selected
      if (mem_access && !io_access)
         space_kind_field = `SK_MEM;
      else if (io_access && !mem_access)
         space_kind_field = `SK_IO;
      else
         space_kind_field = `SK_OTHER;
   end

   // Layout select: bus beats cache beats translation when several fire
   always @*
   begin
      if (bus_fault)
      begin
         code_nxt  = {`PFX_BUS, participation_field, timed_out,
                      request_kind_field, space_kind_field,
                      hierarchy_level_field};
         class_nxt = 2'h3;
      end
      else if (cache_fault)
      begin
         code_nxt  = {`PFX_CACHE, request_kind_field, transaction_type_field,
                      hierarchy_level_field};
         class_nxt = 2'h2;
      end
      else
      begin
         code_nxt  = {`PFX_TLB, transaction_type_field,
                      hierarchy_level_field};
         class_nxt = 2'h1;
      end
   end

   // A new fault overwrites a held code only when overwrite is allowed
   assign can_log = enabled & any_fault & (~valid_r | ctrl_r[`CTRL_OVWR_BIT]);
   assign ev_set  = {enabled & any_fault & valid_r, enabled & bus_fault,
                     enabled & cache_fault & ~bus_fault,
                     enabled & tlb_fault & ~cache_fault & ~bus_fault};

   // Sticky events: a read clears them, but a same-cycle event still lands
   always @*
   begin
      status_nxt = status_r;
      if (rd_en && paddr == `OFS_STATUS)
         status_nxt = 4'h0;
      status_nxt = status_nxt | ev_set;
   end

   // Logging register and control state
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r   <= `CTRL_RST;
         mask_r   <= `MASK_RST;
         status_r <= 4'h0;
         code_r   <= 16'h0000;
         class_r  <= 2'h0;
         valid_r  <= 1'b0;
         over_r   <= 1'b0;
         events_r <= 32'h00000000;
      end
      else
      begin
         status_r <= status_nxt;
         if (can_log)
         begin
            code_r  <= code_nxt;
            class_r <= class_nxt;
         end
         if (enabled && any_fault && valid_r)
            over_r <= 1'b1;
         else if (wr_en && paddr == `OFS_LOG)
            over_r <= 1'b0;
         // Set wins over a software clear of the valid flag
         if (enabled && any_fault)
            valid_r <= 1'b1;
         else if (wr_en && paddr == `OFS_LOG)
            valid_r <= 1'b0;
         if (enabled && any_fault)
            events_r <= events_r + 32'h00000001;
         if (wr_en && paddr == `OFS_CTRL)
            ctrl_r <= pwdata[1:0];
         if (wr_en && paddr == `OFS_MASK)
            mask_r <= pwdata[3:0];
      end
   end

   // Read mux; unmapped offsets read zero and flag an error
   always @*
   begin
      case (paddr)
         `OFS_CTRL:   rdata_nxt = {30'h00000000, ctrl_r};
         `OFS_STATUS: rdata_nxt = {28'h0000000, status_r};
         `OFS_MASK:   rdata_nxt = {28'h0000000, mask_r};
         `OFS_LOG:    rdata_nxt = {valid_r, over_r, 12'h000, class_r, code_r};
         `OFS_EVENTS: rdata_nxt = events_r;
         default:     rdata_nxt = 32'h00000000;
      endcase
   end

   // APB answer: no wait state, data registered in setup cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata          <= 32'h00000000;
         pready          <= 1'b0;
         pslverr         <= 1'b0;
         arch_fault_code <= 16'h0000;
         code_valid      <= 1'b0;
         irq             <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr > `OFS_EVENTS | paddr[1:0] != 2'h0);
         if (psel && !penable)
            prdata <= rdata_nxt;
         arch_fault_code <= can_log ? code_nxt : code_r;
         code_valid      <= (enabled & any_fault) | valid_r;
         irq             <= |(status_nxt & mask_r);
      end
   end
endmodule

// [verification/fault_code_checker.sv]
// Concurrent checks on the fault code encoder outputs
module fault_code_checker
(
   // Clock and reset
   input wire        pclk,
   input wire        presetn,
   // Bus answer
   input wire        pready,
   input wire        pslverr,
   // Fault reports
   input wire        tlb_fault,
   input wire        cache_fault,
   input wire        bus_fault,
   input wire [1:0]  level_in,
   input wire        level_known,
   input wire        timed_out,
   // Logged code
   input wire [15:0] arch_fault_code,
   input wire        code_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Layout decode, shared by the checks below
   wire       tlb_l = arch_fault_code[15:4] == 12'h001;
   wire       cch_l = arch_fault_code[15:8] == 8'h01;
   wire       bus_l = arch_fault_code[15:11] == 5'h01;
   wire       any_f = tlb_fault | cache_fault | bus_fault;
   wire [3:0] rk    = arch_fault_code[7:4];
   layout_legal_a: assert property (code_valid |-> tlb_l || cch_l || bus_l)
      else $error("code has no legal layout");
   type_legal_a: assert property (tlb_l || cch_l |-> arch_fault_code[3:2] != 2'h3)
      else $error("transaction type 11 produced");
   cache_req_a: assert property (cch_l |-> rk <= 4'h8)
      else $error("cache request kind above 1000");
   bus_req_a: assert property (bus_l |-> rk <= 4'h6)
      else $error("eviction or snoop in bus code");
   space_legal_a: assert property (bus_l |-> arch_fault_code[3:2] != 2'h1)
      else $error("reserved space kind produced");
   valid_cause_a: assert property ($rose(code_valid) |-> $past(any_f))
      else $error("valid rose without a fault");
   code_cause_a: assert property ($changed(arch_fault_code) |-> $past(any_f))
      else $error("code changed without a fault");
   timeout_bit_a: assert property ($changed(arch_fault_code) && bus_l |->
      arch_fault_code[8] == $past(timed_out))
      else $error("time-out bit wrong");
   level_field_a: assert property ($changed(arch_fault_code) |->
      arch_fault_code[1:0] == ($past(level_known) ? $past(level_in) : 2'h3))
      else $error("level field wrong");
   // Main scenarios reached
   cover property (pready && pslverr);
   cover property ($changed(arch_fault_code) && bus_l);
   cover property ($changed(arch_fault_code) && cch_l);
endmodule

bind fault_code_encoder fault_code_checker fault_code_checker_i (.pclk(pclk), .presetn(presetn),
   .pready(pready), .pslverr(pslverr), .tlb_fault(tlb_fault), .cache_fault(cache_fault),
   .bus_fault(bus_fault), .level_in(level_in), .level_known(level_known), .timed_out(timed_out),
   .arch_fault_code(arch_fault_code), .code_valid(code_valid));

// [verification/fault_detector_model.sv]
// Behavioural fault detectors feeding strobes and qualifiers
module fault_detector_model
(
   // Clock and bench request
   input  wire        pclk,
   input  wire [2:0]  fire,
   input  wire [15:0] qual,
   // Strobes and qualifiers
   output reg  [2:0]  strb,
   output reg  [15:0] q_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial q_out = 16'h0;
   // Qualifiers toggle outside a strobe so a stale value is never taken for valid
   always @(posedge pclk)
   begin
      strb  <= fire;
      q_out <= (fire != 3'h0) ? qual : ~q_out;
   end
endmodule

// [verification/compound_error_code_encoder_tb_top.sv]
// Self-checking bench for the fault code encoder
`include "fault_code_consts.vh"
module compound_error_code_encoder_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   reg         pclk, presetn, psel, penable, pwrite, err;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg  [2:0]  fire, m;
   reg  [3:0]  mk;
   reg  [15:0] qual, v, e;
   wire [31:0] prdata;
   wire        pready, pslverr, code_valid, irq;
   wire [15:0] arch_fault_code, q;
   wire [2:0]  strb;
   integer     errors, checks, i, a, wb;
   fault_code_encoder fault_code_encoder_i
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tlb_fault(strb[0]), .cache_fault(strb[1]), .bus_fault(strb[2]),
      .instr_known(q[15]), .data_known(q[14]), .level_in(q[13:12]), .level_known(q[11]),
      .is_read(q[10]), .is_write(q[9]), .is_prefetch(q[8]), .is_evict(q[7]), .is_snoop(q[6]),
      .originator_role(q[5]), .answering_role(q[4]), .third_party_role(q[3]),
      .timed_out(q[2]), .mem_access(q[1]), .io_access(q[0]),
      .arch_fault_code(arch_fault_code), .code_valid(code_valid), .irq(irq)
   );
   fault_detector_model fault_detector_model_i
   (
      .pclk(pclk), .fire(fire), .qual(qual), .strb(strb), .q_out(q)
   );
   // Reference code built from the field tables
   function [15:0] model(input [2:0] s, input [15:0] x);
      reg [1:0] tt, ll, pp, sk;
      reg [3:0] rq;
      begin
         tt = (x[15] & ~x[14]) ? 2'h0 : (x[14] & ~x[15]) ? 2'h1 : 2'h2;
         ll = x[11] ? x[13:12] : 2'h3;
         rq = (x[10] & ~x[9]) ? ((tt == 2'h0) ? 4'h5 : (tt == 2'h1) ? 4'h3 : 4'h1)
            : (x[9] & ~x[10]) ? ((tt == 2'h1) ? 4'h4 : 4'h2) : x[8] ? 4'h6
            : (x[7] & s[1] & ~s[2]) ? 4'h7 : (x[6] & s[1] & ~s[2]) ? 4'h8 : 4'h0;
         pp = (x[5:3] == 3'h4) ? 2'h0 : (x[5:3] == 3'h2) ? 2'h1 : (x[5:3] == 3'h1) ? 2'h2 : 2'h3;
         sk = (x[1:0] == 2'h2) ? 2'h0 : (x[1:0] == 2'h1) ? 2'h2 : 2'h3;
         model = s[2] ? {5'h01, pp, x[2], rq, sk, ll}
               : s[1] ? {8'h01, rq, tt, ll} : {12'h001, tt, ll};
      end
   endfunction
   task chk(input string nm, input [31:0] ex, input [31:0] got);
      begin
         checks = checks + 1;
         if (got !== ex)
         begin
            errors = errors + 1;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
         end
      end
   endtask
   // One APB transfer; waits for pready at a rising edge
   task apb(input w, input [11:0] ad, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= ad;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         // Only the watchdog ends a wait for the answer
         while (pready !== 1'b1)
            @(posedge pclk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // Detector strobe; code is due the edge after the strobe
   task fault(input [2:0] s, input [15:0] x);
      begin
         @(posedge pclk);
         fire <= s;
         qual <= x;
         @(posedge pclk);
         fire <= 3'h0;
         @(posedge pclk);
         #1;
      end
   endtask
   task stop_test;
      begin
         $display("errors %0d checks %0d", errors, checks);
         if (errors == 0 && checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // Watchdog well past the expected run
   initial
   begin
      #1000000;
      errors = errors + 1;
      stop_test;
   end
   initial
   begin
      errors = 0;
      checks = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata, fire, qual} = 0;
      i = $urandom(32'h94B1);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `OFS_CTRL, 0);
      chk("ctrl", 32'h1, rd);
      chk("code", 16'h0, arch_fault_code);
      apb(1, `OFS_CTRL, 32'h3);
      for (i = 0; i < 150; i = i + 1)
      begin
         v = $urandom;
         a = $urandom % 6;
         v[10:6] = (a == 0) ? 5'h00 : 5'h10 >> (a - 1);
         m = $urandom % 7 + 1;
         mk = $urandom;
         wb = m[2] ? 2 : m[1] ? 1 : 0;
         // Clear the log so each fault starts without overrun
         apb(1, `OFS_LOG, 0);
         apb(1, `OFS_MASK, {28'h0, mk});
         chk("irq idle", 0, irq);
         fault(m, v);
         e = model(m, v);
         chk("code", e, arch_fault_code);
         chk("code fields", e[8:0], arch_fault_code[8:0]);
         chk("valid", 1, code_valid);
         chk("irq", mk[wb], irq);
         apb(0, `OFS_LOG, 0);
         chk("log", {1'b1, 13'h0, wb[1:0] + 2'h1, e}, rd);
         apb(0, `OFS_STATUS, 0);
         chk("status", 32'h1 << wb, rd);
      end
      // Unmapped and unaligned addresses are refused
      for (i = 0; i < 2; i = i + 1)
      begin
         apb(0, i ? 12'h014 : 12'h002, 0);
         chk("slverr", 1, err);
         chk("rdata", 0, rd);
      end
      // With overwrite off a second fault keeps the first code
      apb(1, `OFS_CTRL, 32'h1);
      apb(1, `OFS_LOG, 0);
      v = $urandom & 16'hFE3F;
      fault(3'h2, v);
      e = model(3'h2, v);
      fault(3'h4, ~v);
      chk("kept code", e, arch_fault_code);
      apb(0, `OFS_LOG, 0);
      chk("over", 1, rd[30]);
      apb(0, `OFS_STATUS, 0);
      chk("overrun", 1, rd[3]);
      // With logging disabled a fault neither logs nor counts
      apb(1, `OFS_CTRL, 32'h0);
      apb(1, `OFS_LOG, 0);
      fault(3'h1, ~v);
      chk("idle code", e, arch_fault_code);
      chk("idle valid", 0, code_valid);
      apb(0, `OFS_EVENTS, 0);
      chk("events", 152, rd);
      stop_test;
   end
endmodule
